// ===== core/cswk_map.svh
`ifndef CSWK_MAP_SVH
`define CSWK_MAP_SVH
// register byte addresses
`define CSWK_A_CTRL     8'h00
`define CSWK_A_STAT     8'h04
`define CSWK_A_OSC_H    8'h08
`define CSWK_A_OSC_L    8'h0C
`define CSWK_A_TRIM     8'h10
`define CSWK_A_FDFLT    8'h14
`define CSWK_A_CDR      8'h18
// control register fields
`define CSWK_F_MODE     2:0
`define CSWK_F_CAL      3
`define CSWK_F_TRIMEN   5:4
`define CSWK_F_FDEN     6
`define CSWK_F_ERRDIS   7
`define CSWK_F_CDREN    8
`define CSWK_F_RXSEL    9
// status register fields; the measured period field sits in the CDR register
`define CSWK_F_BUSWK    0
`define CSWK_F_WUP      1
`define CSWK_F_WUF      2
`define CSWK_F_SELECTIVE_WAKE_ERROR   3
`define CSWK_F_SIL      4
`define CSWK_F_FRAME_ERROR_COUNT     10:5
`define CSWK_F_MEAS     15:8
// transceiver mode codes, trim enable code and counter overflow value
`define CSWK_M_OFF      3'h0
`define CSWK_M_WK       3'h1
`define CSWK_M_SWK      3'h5
`define CSWK_TRIM_ON    2'h3
`define CSWK_FRAME_ERROR_COUNT_OVF   6'h20
// reset values
`define CSWK_RST_FLT    8'h04
`define CSWK_RST_PER    8'h10
// bus silence: least time in ms, clock in kHz
`define CSWK_SIL_MIN_MS 600
`define CSWK_CLK_KHZ    100000
`define CSWK_SIL_CYC    (`CSWK_SIL_MIN_MS * `CSWK_CLK_KHZ)
`define CSWK_SIL_W      26
`endif

// ===== core/cswk_pkg.sv
package cswk_pkg;
    typedef enum logic [1:0] {
        DEC_IDLE  = 2'b00,
        DEC_FRAME = 2'b01,
        DEC_SKIP  = 2'b10
    } cswk_dec_e;
    typedef enum logic [1:0] {
        SBC_NORMAL   = 2'b00,
        SBC_STOP     = 2'b01,
        SBC_SLEEP    = 2'b10,
        SBC_FAILSAFE = 2'b11
    } cswk_sbc_e;
    typedef struct packed {
        logic rx_s1; logic rx_s2; logic rx_prev;
        logic tx_s1; logic tx_s2; logic tx_prev;
        cswk_sbc_e sbc_prev;
        logic [2:0] can_mode; logic oscillator_calibrate; logic [1:0] trim_en;
        logic fd_en; logic err_dis; logic clock_recovery_enable; logic rx_sel;
        logic bus_wake; logic wake_pattern_flag; logic wake_frame_flag; logic selective_wake_error; logic silence;
        logic [25:0] sil_cnt; logic [5:0] frame_error_count;
        cswk_dec_e dec; logic fd_frame; logic [7:0] dom_cnt;
        logic cal_busy; logic [15:0] cal_cnt; logic [15:0] osc_count;
        logic [7:0] trim; logic [7:0] fd_filter; logic [7:0] nom_period;
        logic [7:0] meas; logic meas_valid; logic [7:0] bit_period;
        logic restart_req; logic wake_irq;
        logic [31:0] prdata; logic pslverr;
    } cswk_state_s;
endpackage

// ===== core/cswk_top.sv
// How it works
// - restart from normal: off modes kept, 010/011 become 001, error flag kept
// - restart from normal: 101/110/111 become 101 and error flag is set
// - matching wake frame in sleep: mode 101, bus wake and frame flags set
// - counter overflow wake: error and bus wake set, frame flag cleared, count 32
// - pattern wake with failed selective setup sets error, bus wake, pattern flags
// - other wake sources leave bus wake and frame flags cleared, mode kept
// - frame wake sets pattern flag only if the bus silence timeout passed
// - pattern flag may stay clear after silence, e.g. on counter overflow
// - fail-safe entry forces plain wake capable mode
// - bus wake restarts from sleep, interrupts in normal or stop
// - calibrate bit and transceiver off: host pulse length counted, readable
// - trim writes only act while trim enable is 11 and calibrate is 1
// - tolerant mode: FD frames skipped, unchecked, never wake
// - tolerant mode: decoder ready again at end of an FD frame
// - control field FDF bit 1 marks FD frame, 0 a classic frame
// - tolerant mode dominant filter sets least FD dominant length
// - tolerant off: counter up on FD or bad frame, down on good
// - tolerant on, counter enabled: counter down on any correct frame
// - tolerant on and counter disabled: counter held at zero
// - counter disable bit cleared when bus silence timeout expires
// - clock recovery enabled: bit stream measured, decode period adjusted
// - selective wake on only while error flag reads zero, e.g. no overflow
// - bus silence timeout lies between 0.6 and 1.2 seconds
`timescale 1ns/10ps
`default_nettype none
`include "cswk_map.svh"
module cswk_top #(
    parameter int SILENCE_CYCLES = `CSWK_SIL_CYC
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              rxd_pin,
    input  wire logic              transmit_pin,
    input  wire cswk_pkg::cswk_sbc_e sbc_mode,
    input  wire logic              restart_from_normal,
    input  wire logic              failsafe_enter,
    input  wire logic              wake_pattern_det,
    input  wire logic              ctrl_field_strobe,
    input  wire logic              ctrl_fdf,
    input  wire logic              frame_end,
    input  wire logic              frame_ok,
    input  wire logic              frame_match,
    input  wire logic              eof_strobe,
    output logic                   restart_req,
    output logic                   wake_irq,
    output logic      [7:0]        osc_trim,
    output logic      [7:0]        decode_bit_period,
    output logic                   frame_detect_receiver_select,
    output logic                   selective_wake_active
);
    import cswk_pkg::*;

    localparam logic [25:0] SIL_LAST = 26'(SILENCE_CYCLES - 1);

    cswk_state_s st_reg;
    cswk_state_s st_next;
    logic        rx_dom;
    logic        wr_acc;
    logic        rd_setup;
    logic        swk_sel;
    logic        swk_on;
    logic        wk_armed;
    logic        activity;
    logic        sil_exp;
    logic        wake;

    assign rx_dom   = ~st_reg.rx_s2;
    assign wr_acc   = psel & penable & pwrite;
    assign rd_setup = psel & ~penable;
    assign swk_sel  = st_reg.can_mode[2] & (st_reg.can_mode[1:0] != 2'h0);
    assign swk_on   = swk_sel & ~st_reg.selective_wake_error;
    assign wk_armed = (st_reg.can_mode[1:0] != 2'h0) & ~st_reg.bus_wake;
    // glitches shorter than the filter do not count inside a skipped FD frame
    assign activity = rx_dom & ((st_reg.dec != DEC_SKIP) |
                      (st_reg.dom_cnt >= st_reg.fd_filter));
    assign sil_exp  = ~activity & ~st_reg.silence &
                      (st_reg.sil_cnt == SIL_LAST);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_next = st_reg;
        wake = 1'b0;
        st_next.rx_s1 = rxd_pin;
        st_next.rx_s2 = st_reg.rx_s1;
        st_next.rx_prev = st_reg.rx_s2;
        st_next.tx_s1 = transmit_pin;
        st_next.tx_s2 = st_reg.tx_s1;
        st_next.tx_prev = st_reg.tx_s2;
        st_next.sbc_prev = sbc_mode;
        st_next.restart_req = 1'b0;
        st_next.wake_irq = 1'b0;
        // register writes, taken in the access phase
        if (wr_acc) begin
            unique case (paddr)
                `CSWK_A_CTRL: begin
                    st_next.can_mode = pwdata[`CSWK_F_MODE];
                    st_next.oscillator_calibrate  = pwdata[`CSWK_F_CAL];
                    st_next.trim_en  = pwdata[`CSWK_F_TRIMEN];
                    st_next.fd_en    = pwdata[`CSWK_F_FDEN];
                    st_next.err_dis  = pwdata[`CSWK_F_ERRDIS];
                    st_next.clock_recovery_enable   = pwdata[`CSWK_F_CDREN];
                    st_next.rx_sel   = pwdata[`CSWK_F_RXSEL];
                end
                `CSWK_A_STAT: begin
                    // write one to clear; hardware sets below win
                    if (pwdata[`CSWK_F_BUSWK]) st_next.bus_wake = 1'b0;
                    if (pwdata[`CSWK_F_WUP]) st_next.wake_pattern_flag = 1'b0;
                    if (pwdata[`CSWK_F_WUF]) st_next.wake_frame_flag = 1'b0;
                    if (pwdata[`CSWK_F_SELECTIVE_WAKE_ERROR] & swk_sel) begin
                        st_next.selective_wake_error = 1'b0;
                        st_next.frame_error_count = 6'h00;
                    end
                end
                `CSWK_A_TRIM: begin
                    if (st_reg.trim_en == `CSWK_TRIM_ON && st_reg.oscillator_calibrate) begin
                        st_next.trim = pwdata[7:0];
                    end
                end
                `CSWK_A_FDFLT: st_next.fd_filter = pwdata[7:0];
                `CSWK_A_CDR:   st_next.nom_period = pwdata[7:0];
                default: ;
            endcase
        end
        // dominant run length and bus silence timer
        if (rx_dom) begin
            if (st_reg.dom_cnt != 8'hFF) st_next.dom_cnt = st_reg.dom_cnt + 8'h01;
        end else begin
            st_next.dom_cnt = 8'h00;
        end
        if (activity) begin
            st_next.sil_cnt = '0;
            st_next.silence = 1'b0;
        end else if (st_reg.sil_cnt != SIL_LAST) begin
            st_next.sil_cnt = st_reg.sil_cnt + 26'h000_0001;
        end
        if (sil_exp) begin
            st_next.silence = 1'b1;
            st_next.err_dis = 1'b0;
        end
        // frame decoder; counter only runs while selective wake is live
        unique case (st_reg.dec)
            DEC_IDLE: begin
                if (ctrl_field_strobe) begin
                    st_next.fd_frame = ctrl_fdf;
                    st_next.dec = (st_reg.fd_en & ctrl_fdf) ?
                                  DEC_SKIP : DEC_FRAME;
                end
            end
            DEC_FRAME: begin
                if (frame_end) begin
                    st_next.dec = DEC_IDLE;
                    if (swk_on) begin
                        if (!st_reg.fd_en & (st_reg.fd_frame | !frame_ok)) begin
                            if (st_reg.frame_error_count != `CSWK_FRAME_ERROR_COUNT_OVF)
                                st_next.frame_error_count = st_reg.frame_error_count + 6'h01;
                        end else if (frame_ok && st_reg.frame_error_count != 6'h00) begin
                            st_next.frame_error_count = st_reg.frame_error_count - 6'h01;
                        end
                    end
                    if (frame_ok & frame_match & !st_reg.fd_frame &
                        swk_on & wk_armed) begin
                        wake = 1'b1;
                        st_next.bus_wake = 1'b1;
                        st_next.wake_frame_flag = 1'b1;
                        st_next.selective_wake_error = 1'b0;
                        st_next.wake_pattern_flag = st_reg.silence;
                    end
                end
            end
            DEC_SKIP: begin
                // no stuffing, CRC or form checks and no wake in here
                if (eof_strobe) begin
                    st_next.dec = DEC_IDLE;
                    if (swk_on & st_reg.fd_en & !st_reg.err_dis &
                        st_reg.frame_error_count != 6'h00)
                        st_next.frame_error_count = st_reg.frame_error_count - 6'h01;
                end
            end
            default: st_next.dec = DEC_IDLE;
        endcase
        if (st_reg.fd_en & st_reg.err_dis) st_next.frame_error_count = 6'h00;
        // overflow: pattern flag is left as it stands
        if (st_next.frame_error_count == `CSWK_FRAME_ERROR_COUNT_OVF && st_reg.frame_error_count != `CSWK_FRAME_ERROR_COUNT_OVF) begin
            st_next.selective_wake_error = 1'b1;
            st_next.bus_wake = 1'b1;
            st_next.wake_frame_flag = 1'b0;
            wake = wk_armed;
        end
        // plain wake pattern; selective setup that failed shows as error
        if (wake_pattern_det & wk_armed & !swk_on) begin
            wake = 1'b1;
            st_next.bus_wake = 1'b1;
            st_next.wake_pattern_flag = 1'b1;
            st_next.wake_frame_flag = 1'b0;
            st_next.silence = 1'b0;
            if (swk_sel) st_next.selective_wake_error = 1'b1;
        end
        if (wake) begin
            if (sbc_mode == SBC_SLEEP || sbc_mode == SBC_FAILSAFE)
                st_next.restart_req = 1'b1;
            else
                st_next.wake_irq = 1'b1;
        end
        // sleep entry rearms; a wake from another source then finds them clear
        if (sbc_mode == SBC_SLEEP && st_reg.sbc_prev != SBC_SLEEP) begin
            st_next.bus_wake = 1'b0;
            st_next.wake_frame_flag = 1'b0;
            st_next.wake_pattern_flag = 1'b0;
        end
        // mode changes forced by the system state machine
        if (restart_from_normal) begin
            unique case (st_reg.can_mode)
                3'h2, 3'h3: st_next.can_mode = `CSWK_M_WK;
                3'h5, 3'h6, 3'h7: begin
                    st_next.can_mode = `CSWK_M_SWK;
                    st_next.selective_wake_error = 1'b1;
                end
                default: ;
            endcase
        end
        if (failsafe_enter) st_next.can_mode = `CSWK_M_WK;
        // oscillator measurement of a low host pulse
        if (st_reg.oscillator_calibrate && st_reg.can_mode == `CSWK_M_OFF) begin
            if (st_reg.tx_prev & !st_reg.tx_s2) begin
                st_next.cal_busy = 1'b1;
                st_next.cal_cnt = 16'h0001;
            end else if (st_reg.cal_busy & st_reg.tx_s2) begin
                st_next.cal_busy = 1'b0;
                st_next.osc_count = st_reg.cal_cnt;
            end else if (st_reg.cal_busy && st_reg.cal_cnt != 16'hFFFF) begin
                st_next.cal_cnt = st_reg.cal_cnt + 16'h0001;
            end
        end else begin
            st_next.cal_busy = 1'b0;
        end
        // clock recovery keeps the shortest dominant run as the bit period;
        // switching it mid-frame would skew decoding, hence host keeps bus off
        if (!st_reg.clock_recovery_enable) begin
            st_next.meas_valid = 1'b0;
        end else if (!st_reg.rx_prev & st_reg.rx_s2) begin
            if (!st_reg.meas_valid || st_reg.dom_cnt < st_reg.meas) begin
                st_next.meas = st_reg.dom_cnt;
                st_next.meas_valid = 1'b1;
            end
        end
        st_next.bit_period = (st_reg.clock_recovery_enable & st_reg.meas_valid) ?
                             st_reg.meas : st_reg.nom_period;
        // read data is captured in the setup phase, zero wait states
        if (rd_setup) begin
            st_next.prdata = 32'h0000_0000;
            st_next.pslverr = 1'b0;
            unique case (paddr)
                `CSWK_A_CTRL: begin
                    st_next.prdata[`CSWK_F_MODE] = st_reg.can_mode;
                    st_next.prdata[`CSWK_F_CAL] = st_reg.oscillator_calibrate;
                    st_next.prdata[`CSWK_F_TRIMEN] = st_reg.trim_en;
                    st_next.prdata[`CSWK_F_FDEN] = st_reg.fd_en;
                    st_next.prdata[`CSWK_F_ERRDIS] = st_reg.err_dis;
                    st_next.prdata[`CSWK_F_CDREN] = st_reg.clock_recovery_enable;
                    st_next.prdata[`CSWK_F_RXSEL] = st_reg.rx_sel;
                end
                `CSWK_A_STAT: begin
                    st_next.prdata[`CSWK_F_BUSWK] = st_reg.bus_wake;
                    st_next.prdata[`CSWK_F_WUP] = st_reg.wake_pattern_flag;
                    st_next.prdata[`CSWK_F_WUF] = st_reg.wake_frame_flag;
                    st_next.prdata[`CSWK_F_SELECTIVE_WAKE_ERROR] = st_reg.selective_wake_error;
                    st_next.prdata[`CSWK_F_SIL] = st_reg.silence;
                    st_next.prdata[`CSWK_F_FRAME_ERROR_COUNT] = st_reg.frame_error_count;
                end
                `CSWK_A_OSC_H: st_next.prdata[7:0] = st_reg.osc_count[15:8];
                `CSWK_A_OSC_L: st_next.prdata[7:0] = st_reg.osc_count[7:0];
                `CSWK_A_TRIM:  st_next.prdata[7:0] = st_reg.trim;
                `CSWK_A_FDFLT: st_next.prdata[7:0] = st_reg.fd_filter;
                `CSWK_A_CDR: begin
                    st_next.prdata[7:0] = st_reg.nom_period;
                    st_next.prdata[`CSWK_F_MEAS] = st_reg.meas;
                end
                default: st_next.pslverr = 1'b1;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
            st_reg.rx_s1 <= 1'b1;
            st_reg.rx_s2 <= 1'b1;
            st_reg.rx_prev <= 1'b1;
            st_reg.tx_s1 <= 1'b1;
            st_reg.tx_s2 <= 1'b1;
            st_reg.tx_prev <= 1'b1;
            st_reg.sbc_prev <= SBC_NORMAL;
            st_reg.dec <= DEC_IDLE;
            st_reg.fd_filter <= `CSWK_RST_FLT;
            st_reg.nom_period <= `CSWK_RST_PER;
            st_reg.bit_period <= `CSWK_RST_PER;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = 1'b1;
    assign pslverr = st_reg.pslverr & psel & penable;
    assign restart_req = st_reg.restart_req;
    assign wake_irq = st_reg.wake_irq;
    assign osc_trim = st_reg.trim;
    assign decode_bit_period = st_reg.bit_period;
    assign frame_detect_receiver_select = st_reg.rx_sel;
    assign selective_wake_active = swk_on;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence trim_locked_write;
        wr_acc && paddr == `CSWK_A_TRIM &&
        !(st_reg.trim_en == `CSWK_TRIM_ON && st_reg.oscillator_calibrate);
    endsequence
    sequence cal_pulse_ends;
        st_reg.cal_busy && st_reg.tx_s2 && st_reg.oscillator_calibrate &&
        st_reg.can_mode == `CSWK_M_OFF;
    endsequence
    a_restart_swk_mode: assert property (restart_from_normal
        && !failsafe_enter && swk_sel
        |=> st_reg.can_mode == `CSWK_M_SWK && st_reg.selective_wake_error)
        else $error("restart did not fold selective mode to 101");
    a_restart_plain_mode: assert property (restart_from_normal
        && !wr_acc && !failsafe_enter && st_reg.can_mode[2:1] == 2'b01
        |=> st_reg.can_mode == `CSWK_M_WK && $stable(st_reg.selective_wake_error))
        else $error("restart did not fold plain mode to 001");
    a_failsafe_mode: assert property (failsafe_enter
        |=> st_reg.can_mode == `CSWK_M_WK)
        else $error("fail-safe entry did not force wake capable");
    a_frame_error_count_held_zero: assert property (st_reg.fd_en
        && st_reg.err_dis |=> st_reg.frame_error_count == 6'h00)
        else $error("error counter not held at zero");
    a_silence_clears_dis: assert property (sil_exp
        |=> !st_reg.err_dis && st_reg.silence)
        else $error("silence expiry left counter disable set");
    a_overflow_flags: assert property (
        $rose(st_reg.frame_error_count == `CSWK_FRAME_ERROR_COUNT_OVF)
        |-> st_reg.selective_wake_error && st_reg.bus_wake && !st_reg.wake_frame_flag)
        else $error("overflow wake flags wrong");
    a_fd_skip_nowake: assert property (st_reg.dec == DEC_SKIP
        |=> !$rose(st_reg.wake_frame_flag))
        else $error("wake frame flag rose inside FD frame");
    a_fd_eof_ready: assert property (st_reg.dec == DEC_SKIP
        && eof_strobe |=> st_reg.dec == DEC_IDLE ##1 st_reg.dec != DEC_SKIP)
        else $error("decoder not ready after FD end of frame");
    a_trim_gate: assert property (trim_locked_write
        |=> $stable(st_reg.trim))
        else $error("trim changed while trimming disabled");
    a_osc_capture: assert property (cal_pulse_ends
        |=> st_reg.osc_count == $past(st_reg.cal_cnt) && !st_reg.cal_busy)
        else $error("oscillator count not captured");
    a_wake_route: assert property (wake && sbc_mode == SBC_SLEEP
        |=> restart_req && !wake_irq)
        else $error("sleep wake did not request restart");
endmodule
`default_nettype wire

// ===== dv/cswk_bus_model.sv
`timescale 1ns/10ps
`default_nettype none
// far-side frame source: a control field, then the end of the frame
module cswk_bus_model (
    input  wire logic pclk,
    input  wire logic go,
    input  wire logic fdf,
    input  wire logic ok,
    input  wire logic match,
    output logic      ctrl_field_strobe = 1'b0,
    output logic      ctrl_fdf = 1'b0,
    output logic      frame_end = 1'b0,
    output logic      frame_ok = 1'b0,
    output logic      frame_match = 1'b0,
    output logic      eof_strobe = 1'b0,
    output logic      rxd_pin = 1'b1
);
    logic [2:0] cnt = 3'h0;
    // qualifiers show the inverse outside their strobe, never a kind value
    always @(posedge pclk) begin
        ctrl_field_strobe <= 1'b0;
        frame_end <= 1'b0;
        eof_strobe <= 1'b0;
        ctrl_fdf <= ~fdf;
        frame_ok <= ~ok;
        frame_match <= ~match;
        if (go) begin
            ctrl_field_strobe <= 1'b1;
            ctrl_fdf <= fdf;
            cnt <= 3'h4;
        end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            if (cnt == 3'h1 && fdf)
                eof_strobe <= 1'b1;
            else if (cnt == 3'h1) begin
                frame_end <= 1'b1;
                frame_ok <= ok;
                frame_match <= match;
            end
        end
    end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "cswk_map.svh"
module testbench;
    import cswk_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, transmit_pin = 1'b1, rst_norm = 1'b0;
    logic fs_enter = 1'b0, wup_det = 1'b0, go = 1'b0, fdf = 1'b0;
    logic ok = 1'b0, match = 1'b0, perr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, r, r2;
    cswk_sbc_e sbc_mode = SBC_NORMAL;
    logic [31:0] prdata;
    logic pready, pslverr, restart_req, wake_irq, cfs, cfdf, fe, fok, fm;
    logic eof, rxd, rxsel, swk_act;
    logic [7:0] osc_trim, dbp;
    int n_fail = 0, num_checks = 0, n_restart = 0, n_irq = 0;
    logic [2:0] exp_m [8] = '{3'h0, 3'h1, 3'h1, 3'h1, 3'h4, 3'h5, 3'h5, 3'h5};
    cswk_top #(.SILENCE_CYCLES(50)) u_cswk_top (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd_pin(rxd),
        .transmit_pin(transmit_pin), .sbc_mode(sbc_mode),
        .restart_from_normal(rst_norm), .failsafe_enter(fs_enter),
        .wake_pattern_det(wup_det), .ctrl_field_strobe(cfs),
        .ctrl_fdf(cfdf), .frame_end(fe), .frame_ok(fok),
        .frame_match(fm), .eof_strobe(eof), .restart_req(restart_req),
        .wake_irq(wake_irq), .osc_trim(osc_trim), .decode_bit_period(dbp),
        .frame_detect_receiver_select(rxsel),
        .selective_wake_active(swk_act));
    cswk_bus_model u_cswk_bus_model (
        .pclk(pclk), .go(go), .fdf(fdf), .ok(ok), .match(match),
        .ctrl_field_strobe(cfs), .ctrl_fdf(cfdf), .frame_end(fe),
        .frame_ok(fok), .frame_match(fm), .eof_strobe(eof), .rxd_pin(rxd));
    always #5 pclk = ~pclk;
    // wake pulses last one cycle, so they are counted rather than polled
    always @(posedge pclk) begin
        if (restart_req === 1'b1) n_restart++;
        if (wake_irq === 1'b1) n_irq++;
    end
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // only the watchdog ends a wait for the slave
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        q = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // callers compare outputs only after the access edge has settled
        @(negedge pclk);
    endtask
    task automatic frame(input logic f, input logic o, input logic m);
        @(posedge pclk);
        go <= 1'b1;
        fdf <= f;
        ok <= o;
        match <= m;
        @(posedge pclk);
        go <= 1'b0;
        repeat (7) @(posedge pclk);
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        n_fail++;
        summarize;
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b1, `CSWK_A_CTRL, 32'(i), r);
            @(posedge pclk) rst_norm <= 1'b1;
            @(posedge pclk) rst_norm <= 1'b0;
            apb(1'b0, `CSWK_A_CTRL, 32'h0, r);
            apb(1'b0, `CSWK_A_STAT, 32'h0, r2);
            chk(32'(r[2:0]), 32'(exp_m[i]));
            chk(32'(r2[3]), 32'(i > 4));
        end
        $display("test restart rows done");
        chk(32'(dbp), 32'h0000_0010);
        apb(1'b0, `CSWK_A_FDFLT, 32'h0, r);
        chk(r, 32'h0000_0004);
        apb(1'b0, 8'h40, 32'h0, r);
        chk({r[30:0], perr}, 32'h0000_0001);
        apb(1'b1, `CSWK_A_STAT, 32'h0000_0008, r);
        chk(32'(swk_act), 32'h1);
        @(posedge pclk) sbc_mode <= SBC_SLEEP;
        repeat (60) @(posedge pclk);
        frame(1'b0, 1'b1, 1'b1);
        chk(32'(n_restart), 32'h1);
        apb(1'b0, `CSWK_A_STAT, 32'h0, r);
        chk(32'(r[3:0]), 32'h0000_0007);
        apb(1'b0, `CSWK_A_CTRL, 32'h0, r);
        chk(32'(r[2:0]), 32'h0000_0005);
        $display("test frame wake done");
        sbc_mode <= SBC_NORMAL;
        apb(1'b1, `CSWK_A_STAT, 32'h0000_0007, r);
        for (int i = 0; i < 31; i++)
            frame(1'b0, 1'b0, 1'b0);
        apb(1'b0, `CSWK_A_STAT, 32'h0, r);
        chk(32'(r[10:5]), 32'h0000_001F);
        chk(32'(n_irq), 32'h0);
        frame(1'b0, 1'b0, 1'b0);
        apb(1'b0, `CSWK_A_STAT, 32'h0, r);
        chk(32'(r[10:5]), 32'h0000_0020);
        chk(32'({r[3:2], r[0]}), 32'h0000_0005);
        chk(32'(n_irq), 32'h1);
        $display("test counter overflow done");
        @(posedge pclk) fs_enter <= 1'b1;
        @(posedge pclk) fs_enter <= 1'b0;
        apb(1'b0, `CSWK_A_CTRL, 32'h0, r);
        chk(32'(r[2:0]), 32'h1);
        chk(32'(swk_act), 32'h0);
        $display("test fail-safe done");
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0008, r);
        @(posedge pclk) transmit_pin <= 1'b0;
        repeat (20) @(posedge pclk);
        transmit_pin <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1'b0, `CSWK_A_OSC_H, 32'h0, r);
        apb(1'b0, `CSWK_A_OSC_L, 32'h0, r2);
        r = {16'h0000, r[7:0], r2[7:0]};
        chk(32'(r >= 19 && r <= 22), 32'h1);
        apb(1'b1, `CSWK_A_TRIM, 32'h0000_005A, r);
        chk(32'(osc_trim), 32'h0);
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0038, r);
        apb(1'b1, `CSWK_A_TRIM, 32'h0000_005A, r);
        chk(32'(osc_trim), 32'h0000_005A);
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0008, r);
        apb(1'b1, `CSWK_A_TRIM, 32'h0000_0033, r);
        chk(32'(osc_trim), 32'h0000_005A);
        $display("test calibration done");
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0005, r);
        apb(1'b1, `CSWK_A_STAT, 32'h0000_000F, r);
        frame(1'b0, 1'b0, 1'b0);
        frame(1'b0, 1'b0, 1'b0);
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0045, r);
        frame(1'b1, 1'b1, 1'b1);
        apb(1'b0, `CSWK_A_STAT, 32'h0, r);
        chk(32'({r[10:5], r[2:0]}), 32'h0000_0008);
        chk(32'(n_irq), 32'h1);
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_00C5, r);
        apb(1'b0, `CSWK_A_STAT, 32'h0, r);
        chk(32'(r[10:5]), 32'h0);
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0000, r);
        apb(1'b1, `CSWK_A_CTRL, 32'h0000_0100, r);
        apb(1'b0, `CSWK_A_CDR, 32'h0, r);
        chk(r, 32'h0000_0010);
        chk(32'(dbp), 32'h0000_0010);
        $display("test fd tolerant and clock recovery done");
        summarize;
    end
endmodule
`default_nettype wire
